// file: cable_ctrl_pkg.sv
// constants, field layouts and carrier types of the cable module control register bank
package cable_ctrl_pkg;

  // serial management bus
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // lower map
  localparam logic [7:0] STATUS_OFS = 8'h03;
  localparam int unsigned STATUS_LOS_BIT = 0;
  localparam logic [7:0] TEMP_MSB_OFS = 8'h16;
  localparam logic [7:0] TEMP_LSB_OFS = 8'h17;
  localparam logic [7:0] VCC_MSB_OFS = 8'h1a;
  localparam logic [7:0] VCC_LSB_OFS = 8'h1b;
  localparam logic [7:0] PAGE_SEL_OFS = 8'h7f;
  localparam logic [7:0] UPPER_BASE = 8'h80;

  // upper pages
  localparam logic [7:0] CTRL_PAGE = 8'h03;
  localparam logic [7:0] VENDOR_PAGE = 8'h07;
  localparam logic [7:0] LANE_OUTPUT_CONTROL_OFS = 8'he2;
  localparam logic [7:0] POWER_ON_DEFAULT_IMAGE_OFS = 8'he2;
  localparam logic [7:0] TEMPERATURE_CAL_OFFSET_OFS = 8'he3;
  localparam logic [7:0] TEMPERATURE_CAL_GAIN_OFS = 8'he4;
  localparam logic [7:0] VOLTAGE_CAL_OFFSET_OFS = 8'he5;
  localparam logic [7:0] VOLTAGE_CAL_GAIN_OFS = 8'he6;

  // control byte field positions
  localparam int unsigned HOST_EMPHASIS_LEVEL_BIT = 0;
  localparam int unsigned RX_DISABLE_BIT = 1;
  localparam int unsigned CABLE_EMPHASIS_BASE_BIT = 2;
  localparam int unsigned CABLE_EMPHASIS_BOOST_BIT = 3;
  localparam int unsigned TX_DISABLE_BIT = 4;
  localparam logic [7:0] CTRL_USED_MASK = 8'h1f;

  // reset values
  localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h12;
  localparam logic [7:0] DEFAULT_IMAGE_RESET = 8'h00;
  localparam logic [7:0] CAL_OFFSET_RESET = 8'h00;
  localparam logic [7:0] CAL_GAIN_RESET = 8'h10;

  // emphasis figures in decibels
  localparam logic [3:0] EMPH_LOW_DB = 4'h3;
  localparam logic [3:0] EMPH_HIGH_DB = 4'h6;
  localparam logic [3:0] EMPH_BOOST_DB = 4'h6;
  localparam logic [3:0] EMPH_NONE_DB = 4'h0;

  // gain is unsigned with four fraction bits
  localparam int unsigned CAL_FRAC_BITS = 4;

  typedef struct packed {
    logic [2:0] unused;
    logic tx_disable;
    logic cable_emphasis_boost;
    logic cable_emphasis_base;
    logic rx_disable;
    logic host_emphasis_level;
  } lane_ctrl_t;

  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] gain;
  } cal_pair_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ACK_ADDR = 4'b0010,
    ST_WORD = 4'b0011,
    ST_ACK_WORD = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_ACK_WDATA = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RACK = 4'b1000
  } bus_state_t;

endpackage : cable_ctrl_pkg

// file: monitor_cal.sv
// applies gain and offset calibration to one raw monitor reading
`timescale 1ns/10ps
module monitor_cal
  import cable_ctrl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // raw reading and constants
  input wire logic [15:0] raw,
  input wire cal_pair_t cal,
  // calibrated reading
  output logic [15:0] result
);

  logic [23:0] product;
  logic [20:0] scaled;
  logic [20:0] sum;
  logic [15:0] result_d;
  logic [15:0] result_q;

  always_comb begin
    product = raw * cal.gain;
    scaled = 21'(product >> CAL_FRAC_BITS);
    sum = scaled + 21'(cal.offset);
    // saturate rather than wrap so a hot reading never reads as cold
    result_d = (sum > 21'h00_ffff) ? 16'hffff : sum[15:0];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_q <= 16'h0000;
    end else begin
      result_q <= result_d;
    end
  end

  assign result = result_q;

endmodule : monitor_cal

// file: cable_module_vendor_control_regs.sv
// vendor control and calibration register bank behind the serial management bus
//
// Behaviour
// - control bit 4 set disables all transmitter outputs; clear enables them.
// - control bit 3 adds 6 dB transmit pre-emphasis when set, 0 dB when clear.
// - control bit 1 set disables all receiver outputs; clear re-enables them.
// - control bit 0 sets receiver output pre-emphasis to 6 dB, else 3 dB.
// - page 7 byte 226 holds a power-on default image of the control byte.
// - at power-up the default image is copied into page 3 byte 226 first.
// - page 7 bytes 227 and 228 hold temperature offset and gain, applied to readings.
// - page 7 bytes 229 and 230 hold supply voltage offset and gain.
// - only the transmit-side supply rail is measured and reported.
// - receiver loss of signal is reported; no optical-only items are reported.
// - every location is read and written only over the host serial bus; page 3 byte 226 is also loaded by the power-up copy.
// - status appears only as readable register bits, never on status pins.
`timescale 1ns/10ps
module cable_module_vendor_control_regs
  import cable_ctrl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // serial management bus pins, clock driven by the host
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // signal detector and monitor converters
  input wire logic signal_missing_in,
  input wire logic [15:0] temp_raw,
  input wire logic [15:0] vcc_tx_raw,
  // equalizer controls
  output logic tx_disable,
  output logic rx_disable,
  output logic [3:0] tx_emphasis_db,
  output logic [3:0] rx_emphasis_db
);

  // two-stage synchronisers for the asynchronous pins
  logic [2:0] pin_async;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic scl_prev_q;
  logic sda_prev_q;

  assign pin_async = {signal_missing_in, sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pin_async[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic scl_s;
  logic sda_s;
  logic los_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_s = sync2_q[0];
  assign sda_s = sync2_q[1];
  assign los_s = sync2_q[2];
  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign bus_start = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign bus_stop = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // register state
  logic [7:0] page_sel_q, page_sel_d;
  lane_ctrl_t ctrl_q, ctrl_d;
  // the image outlives rst_n so a stored default reaches the next copy; its initial value stands for an empty store
  lane_ctrl_t image_q = DEFAULT_IMAGE_RESET;
  lane_ctrl_t image_d;
  cal_pair_t temp_cal_q, temp_cal_d;
  cal_pair_t vcc_cal_q, vcc_cal_d;
  logic init_done_q, init_done_d;
  logic [15:0] temp_cal_val;
  logic [15:0] vcc_cal_val;

  // bus state
  bus_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] ptr_q, ptr_d;
  logic rw_q, rw_d;
  logic nack_q, nack_d;
  logic oe_q, oe_d;
  logic wr_en;
  logic [7:0] rd_byte;

  function automatic logic hits(input logic [7:0] ptr, input logic [7:0] page,
                                input logic [7:0] ofs, input logic [7:0] want_page);
    hits = (ptr == ofs) && ((ofs < UPPER_BASE) || (page == want_page));
  endfunction : hits

  monitor_cal u_temp_cal (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .raw(temp_raw),
    .cal(temp_cal_q),
    .result(temp_cal_val)
  );

  // only the transmit-side rail is converted
  monitor_cal u_vcc_cal (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .raw(vcc_tx_raw),
    .cal(vcc_cal_q),
    .result(vcc_cal_val)
  );

  // read mux; loss of signal is the only status bit, no optical faults exist here
  always_comb begin
    rd_byte = 8'h00;
    if (hits(ptr_q, page_sel_q, STATUS_OFS, 8'h00)) begin
      rd_byte[STATUS_LOS_BIT] = los_s;
    end else if (hits(ptr_q, page_sel_q, TEMP_MSB_OFS, 8'h00)) begin
      rd_byte = temp_cal_val[15:8];
    end else if (hits(ptr_q, page_sel_q, TEMP_LSB_OFS, 8'h00)) begin
      rd_byte = temp_cal_val[7:0];
    end else if (hits(ptr_q, page_sel_q, VCC_MSB_OFS, 8'h00)) begin
      rd_byte = vcc_cal_val[15:8];
    end else if (hits(ptr_q, page_sel_q, VCC_LSB_OFS, 8'h00)) begin
      rd_byte = vcc_cal_val[7:0];
    end else if (hits(ptr_q, page_sel_q, PAGE_SEL_OFS, 8'h00)) begin
      rd_byte = page_sel_q;
    end else if (hits(ptr_q, page_sel_q, LANE_OUTPUT_CONTROL_OFS, CTRL_PAGE)) begin
      rd_byte = ctrl_q & CTRL_USED_MASK;
    end else if (hits(ptr_q, page_sel_q, POWER_ON_DEFAULT_IMAGE_OFS, VENDOR_PAGE)) begin
      rd_byte = image_q & CTRL_USED_MASK;
    end else if (hits(ptr_q, page_sel_q, TEMPERATURE_CAL_OFFSET_OFS, VENDOR_PAGE)) begin
      rd_byte = temp_cal_q.offset;
    end else if (hits(ptr_q, page_sel_q, TEMPERATURE_CAL_GAIN_OFS, VENDOR_PAGE)) begin
      rd_byte = temp_cal_q.gain;
    end else if (hits(ptr_q, page_sel_q, VOLTAGE_CAL_OFFSET_OFS, VENDOR_PAGE)) begin
      rd_byte = vcc_cal_q.offset;
    end else if (hits(ptr_q, page_sel_q, VOLTAGE_CAL_GAIN_OFS, VENDOR_PAGE)) begin
      rd_byte = vcc_cal_q.gain;
    end
  end

  // bus protocol engine: sample on clock rise, drive on clock fall
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    nack_d = nack_q;
    oe_d = oe_q;
    wr_en = 1'b0;
    if (bus_start) begin
      state_d = ST_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (bus_stop) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      unique case (state_q)
        ST_ADDR, ST_WORD, ST_WDATA: begin
          shift_d = {shift_q[6:0], sda_s};
          cnt_d = cnt_q + 4'h1;
        end
        ST_RACK: begin
          nack_d = sda_s;
        end
        ST_IDLE, ST_ACK_ADDR, ST_ACK_WORD, ST_ACK_WDATA, ST_RDATA: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state_q)
        ST_ADDR: begin
          if (cnt_q == BITS_PER_BYTE) begin
            if (shift_q[7:1] == DEV_ADDR) begin
              rw_d = shift_q[0];
              oe_d = 1'b1;
              state_d = ST_ACK_ADDR;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_WORD: begin
          if (cnt_q == BITS_PER_BYTE) begin
            ptr_d = shift_q;
            oe_d = 1'b1;
            state_d = ST_ACK_WORD;
          end
        end
        ST_WDATA: begin
          if (cnt_q == BITS_PER_BYTE) begin
            wr_en = 1'b1;
            ptr_d = ptr_q + 8'h01;
            oe_d = 1'b1;
            state_d = ST_ACK_WDATA;
          end
        end
        ST_ACK_ADDR, ST_RACK: begin
          if (state_q == ST_RACK && nack_q) begin
            oe_d = 1'b0;
            state_d = ST_IDLE;
          end else if (state_q == ST_ACK_ADDR && !rw_q) begin
            oe_d = 1'b0;
            cnt_d = 4'h0;
            state_d = ST_WORD;
          end else begin
            shift_d = {rd_byte[6:0], 1'b0};
            oe_d = !rd_byte[7];
            ptr_d = ptr_q + 8'h01;
            cnt_d = 4'h1;
            state_d = ST_RDATA;
          end
        end
        ST_ACK_WORD, ST_ACK_WDATA: begin
          oe_d = 1'b0;
          cnt_d = 4'h0;
          state_d = ST_WDATA;
        end
        ST_RDATA: begin
          if (cnt_q == BITS_PER_BYTE) begin
            oe_d = 1'b0;
            state_d = ST_RACK;
          end else begin
            oe_d = !shift_q[7];
            shift_d = {shift_q[6:0], 1'b0};
            cnt_d = cnt_q + 4'h1;
          end
        end
        ST_IDLE: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      nack_q <= nack_d;
      oe_q <= oe_d;
    end
  end

  // register writes and the power-up copy
  always_comb begin
    page_sel_d = page_sel_q;
    ctrl_d = ctrl_q;
    image_d = image_q;
    temp_cal_d = temp_cal_q;
    vcc_cal_d = vcc_cal_q;
    init_done_d = 1'b1;
    if (!init_done_q) begin
      // outputs stay disabled until the stored defaults are in place
      ctrl_d = image_q & CTRL_USED_MASK;
    end else if (wr_en) begin
      if (hits(ptr_q, page_sel_q, PAGE_SEL_OFS, 8'h00)) begin
        page_sel_d = shift_q;
      end
      if (hits(ptr_q, page_sel_q, LANE_OUTPUT_CONTROL_OFS, CTRL_PAGE)) begin
        ctrl_d = shift_q & CTRL_USED_MASK;
      end
      if (hits(ptr_q, page_sel_q, POWER_ON_DEFAULT_IMAGE_OFS, VENDOR_PAGE)) begin
        image_d = shift_q & CTRL_USED_MASK;
      end
      if (hits(ptr_q, page_sel_q, TEMPERATURE_CAL_OFFSET_OFS, VENDOR_PAGE)) begin
        temp_cal_d.offset = shift_q;
      end
      if (hits(ptr_q, page_sel_q, TEMPERATURE_CAL_GAIN_OFS, VENDOR_PAGE)) begin
        temp_cal_d.gain = shift_q;
      end
      if (hits(ptr_q, page_sel_q, VOLTAGE_CAL_OFFSET_OFS, VENDOR_PAGE)) begin
        vcc_cal_d.offset = shift_q;
      end
      if (hits(ptr_q, page_sel_q, VOLTAGE_CAL_GAIN_OFS, VENDOR_PAGE)) begin
        vcc_cal_d.gain = shift_q;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      page_sel_q <= PAGE_SEL_RESET;
      ctrl_q <= CTRL_RESET;
      temp_cal_q <= {CAL_OFFSET_RESET, CAL_GAIN_RESET};
      vcc_cal_q <= {CAL_OFFSET_RESET, CAL_GAIN_RESET};
      init_done_q <= 1'b0;
    end else begin
      page_sel_q <= page_sel_d;
      ctrl_q <= ctrl_d;
      temp_cal_q <= temp_cal_d;
      vcc_cal_q <= vcc_cal_d;
      init_done_q <= init_done_d;
    end
  end

  // no reset here: clearing the image on rst_n would make the power-up copy always load zero
  always_ff @(posedge core_clk) begin
    image_q <= image_d;
  end

  // equalizer outputs, registered
  logic tx_disable_q, tx_disable_d;
  logic rx_disable_q, rx_disable_d;
  logic [3:0] tx_emph_q, tx_emph_d;
  logic [3:0] rx_emph_q, rx_emph_d;

  always_comb begin
    tx_disable_d = ctrl_q.tx_disable;
    rx_disable_d = ctrl_q.rx_disable;
    tx_emph_d = (ctrl_q.cable_emphasis_base ? EMPH_HIGH_DB : EMPH_LOW_DB)
      + (ctrl_q.cable_emphasis_boost ? EMPH_BOOST_DB : EMPH_NONE_DB);
    rx_emph_d = ctrl_q.host_emphasis_level ? EMPH_HIGH_DB : EMPH_LOW_DB;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_disable_q <= 1'b1;
      rx_disable_q <= 1'b1;
      tx_emph_q <= EMPH_LOW_DB;
      rx_emph_q <= EMPH_LOW_DB;
    end else begin
      tx_disable_q <= tx_disable_d;
      rx_disable_q <= rx_disable_d;
      tx_emph_q <= tx_emph_d;
      rx_emph_q <= rx_emph_d;
    end
  end

  // open-drain data line only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign tx_disable = tx_disable_q;
  assign rx_disable = rx_disable_q;
  assign tx_emphasis_db = tx_emph_q;
  assign rx_emphasis_db = rx_emph_q;

endmodule : cable_module_vendor_control_regs

// file: cable_regs_monitor.sv
// assertions on the ports of the vendor control register bank
`timescale 1ns/10ps
module cable_regs_monitor
  import cable_ctrl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // serial bus
  input wire logic scl_in,
  input wire logic sda_oe,
  // equalizer controls
  input wire logic tx_disable,
  input wire logic rx_disable,
  input wire logic [3:0] tx_emphasis_db,
  input wire logic [3:0] rx_emphasis_db
);
  logic [9:0] ctl;
  assign ctl = {tx_disable, rx_disable, tx_emphasis_db, rx_emphasis_db};
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_reset_state: assert property (
    $rose(rst_n) |-> tx_disable && rx_disable && !sda_oe && ctl[7:0] == {EMPH_LOW_DB, EMPH_LOW_DB})
    else $error("outputs not at reset state on release");
  chk_copy_settles: assert property (
    $rose(rst_n) |-> ##4 $stable(ctl) [*5])
    else $error("controls moved after the default copy");
  chk_tx_emph_set: assert property (
    tx_emphasis_db inside {4'h3, 4'h6, 4'h9, 4'hc})
    else $error("transmit emphasis outside 3 6 9 12");
  chk_rx_emph_set: assert property (
    rx_emphasis_db == EMPH_LOW_DB || rx_emphasis_db == EMPH_HIGH_DB)
    else $error("receiver emphasis outside 3 6");
  chk_oe_rise_low: assert property (
    $rose(sda_oe) |-> !scl_in)
    else $error("data pulled while bus clock high");
  chk_oe_fall_low: assert property (
    $fell(sda_oe) |-> !scl_in)
    else $error("data released while bus clock high");
  chk_oe_hold: assert property (
    $rose(sda_oe) |=> sda_oe [*6])
    else $error("data pull too short");
  chk_ctrl_quiet_high: assert property (
    $past(rst_n, 8) && $changed(ctl) |-> !scl_in)
    else $error("controls changed outside a bus write");
endmodule : cable_regs_monitor

bind cable_module_vendor_control_regs cable_regs_monitor u_monitor (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .scl_in(scl_in),
  .sda_oe(sda_oe),
  .tx_disable(tx_disable),
  .rx_disable(rx_disable),
  .tx_emphasis_db(tx_emphasis_db),
  .rx_emphasis_db(rx_emphasis_db)
);

// file: cable_host_model.sv
// host controller model of the two-wire management bus
`timescale 1ns/10ps
module cable_host_model
  import cable_ctrl_pkg::*;
(
  // clock
  input wire logic core_clk,
  // device side of the data line
  input wire logic sda_out,
  input wire logic sda_oe,
  // wire levels
  output logic scl,
  output logic sda,
  // one cycle per ack (bit 0) or read byte
  output logic res_valid,
  output logic [7:0] res
);
  logic sda_h;
  // pulled up: low whenever either party pulls it
  assign sda = sda_h & ~(sda_oe & ~sda_out);
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
    res_valid = 1'b0;
    res = 8'h00;
  end
  // one phase of eight core clocks; data never moves with a clock edge
  task automatic step(input logic c, input logic d);
    scl <= c;
    sda_h <= d;
    repeat (8) @(posedge core_clk);
  endtask : step
  task automatic report(input logic [7:0] v);
    res <= v;
    res_valid <= 1'b1;
    @(posedge core_clk);
    res_valid <= 1'b0;
  endtask : report
  task automatic start();
    step(scl, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start
  task automatic stop();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop
  task automatic byte_w(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, d[i]);
      step(1'b1, d[i]);
      step(1'b0, d[i]);
    end
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    report({7'h00, ~sda});
    step(1'b0, 1'b1);
  endtask : byte_w
  task automatic byte_r(input logic last);
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      d = {d[6:0], sda};
    end
    step(1'b0, 1'b1);
    report(d);
    step(1'b0, last);
    step(1'b1, last);
    step(1'b0, last);
  endtask : byte_r
endmodule : cable_host_model

// file: cable_module_vendor_control_regs_test.sv
// self-checking bench for the vendor control register bank
`timescale 1ns/10ps
module cable_module_vendor_control_regs_test
  import cable_ctrl_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic signal_missing_in = 1'b0;
  logic [15:0] temp_raw = 16'h0000;
  logic [15:0] vcc_tx_raw = 16'h0000;
  logic scl, sda, sda_out, sda_oe, tx_disable, rx_disable, res_valid;
  logic [3:0] tx_emphasis_db, rx_emphasis_db;
  logic [7:0] res;
  logic [15:0] exp_q[$];
  logic [7:0] cal[4] = '{8'h05, 8'h10, 8'h00, 8'h20};
  int num_errors = 0;
  int checks = 0;
  int seed = 32'h3514977e;

  always #10 core_clk = ~core_clk;

  cable_module_vendor_control_regs uut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .scl_in(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .signal_missing_in(signal_missing_in),
    .temp_raw(temp_raw),
    .vcc_tx_raw(vcc_tx_raw),
    .tx_disable(tx_disable),
    .rx_disable(rx_disable),
    .tx_emphasis_db(tx_emphasis_db),
    .rx_emphasis_db(rx_emphasis_db)
  );
  cable_host_model host (
    .core_clk(core_clk),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .scl(scl),
    .sda(sda),
    .res_valid(res_valid),
    .res(res)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      num_errors++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
  endtask : do_reset
  task automatic bw(input logic [7:0] ofs, input logic [7:0] d);
    repeat (3) exp_q.push_back(16'h0101);
    host.start();
    host.byte_w({DEV_ADDR, 1'b0});
    host.byte_w(ofs);
    host.byte_w(d);
    host.stop();
  endtask : bw
  task automatic br(input logic [7:0] ofs, input logic [7:0] mask, input logic [7:0] want);
    repeat (3) exp_q.push_back(16'h0101);
    exp_q.push_back({mask, want});
    host.start();
    host.byte_w({DEV_ADDR, 1'b0});
    host.byte_w(ofs);
    host.start();
    host.byte_w({DEV_ADDR, 1'b1});
    host.byte_r(1'b1);
    host.stop();
  endtask : br
  task automatic check_ctl(input logic [7:0] v);
    logic [3:0] db;
    db = (v[CABLE_EMPHASIS_BASE_BIT] ? EMPH_HIGH_DB : EMPH_LOW_DB);
    db = db + (v[CABLE_EMPHASIS_BOOST_BIT] ? EMPH_BOOST_DB : EMPH_NONE_DB);
    check({7'h00, tx_disable}, {7'h00, v[TX_DISABLE_BIT]});
    check({7'h00, rx_disable}, {7'h00, v[RX_DISABLE_BIT]});
    check({4'h0, tx_emphasis_db}, {4'h0, db});
    check({4'h0, rx_emphasis_db}, {4'h0, v[HOST_EMPHASIS_LEVEL_BIT] ? EMPH_HIGH_DB : EMPH_LOW_DB});
  endtask : check_ctl

  // oldest note against each ack or read byte the host reports
  always @(posedge core_clk) begin
    if (res_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("[ERR] %0t: result without expectation", $time);
      end else begin
        check(res & exp_q[0][15:8], exp_q[0][7:0]);
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    logic [7:0] v;
    logic [15:0] t;
    logic [15:0] u;
    do_reset();
    check_ctl(8'h00);
    bw(PAGE_SEL_OFS, VENDOR_PAGE);
    for (int i = 0; i < 4; i++) begin
      bw(TEMPERATURE_CAL_OFFSET_OFS + 8'(i), cal[i]);
      br(TEMPERATURE_CAL_OFFSET_OFS + 8'(i), 8'hff, cal[i]);
    end
    br(8'hf0, 8'hff, 8'h00);
    // unity gain plus offset on temperature, double gain on the supply
    t = 16'($random(seed)) & 16'h7fff;
    u = 16'($random(seed)) & 16'h3fff;
    temp_raw <= t;
    vcc_tx_raw <= u;
    t = t + 16'h0005;
    u = u << 1;
    br(TEMP_MSB_OFS, 8'hff, t[15:8]);
    br(TEMP_LSB_OFS, 8'hff, t[7:0]);
    br(VCC_MSB_OFS, 8'hff, u[15:8]);
    br(VCC_LSB_OFS, 8'hff, u[7:0]);
    for (int i = 1; i >= 0; i--) begin
      signal_missing_in <= i[0];
      br(STATUS_OFS, 8'h01, {7'h00, i[0]});
    end
    // another address must go unanswered
    exp_q.push_back(16'h0100);
    host.start();
    host.byte_w({DEV_ADDR ^ 7'h01, 1'b0});
    host.stop();
    bw(PAGE_SEL_OFS, CTRL_PAGE);
    for (int i = 0; i < 32; i++) begin
      v = {3'($random(seed)), i[4:0]};
      bw(LANE_OUTPUT_CONTROL_OFS, v);
      check_ctl(v);
      br(LANE_OUTPUT_CONTROL_OFS, 8'hff, v & CTRL_USED_MASK);
    end
    bw(PAGE_SEL_OFS, VENDOR_PAGE);
    bw(POWER_ON_DEFAULT_IMAGE_OFS, 8'h0d);
    br(POWER_ON_DEFAULT_IMAGE_OFS, 8'hff, 8'h0d);
    do_reset();
    check_ctl(8'h0d);
    bw(PAGE_SEL_OFS, CTRL_PAGE);
    br(LANE_OUTPUT_CONTROL_OFS, 8'hff, 8'h0d);
    for (int k = 0; k < 20 && exp_q.size() != 0; k++) @(posedge core_clk);
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("[ERR] %0t: results missing", $time);
    end
    test_done();
  end

  initial begin
    repeat (90000) @(posedge core_clk);
    num_errors++;
    $display("[ERR] %0t: run did not finish", $time);
    test_done();
  end
endmodule : cable_module_vendor_control_regs_test
